/* File: hdl/peripheral_soft_reset_regs.sv */
// What this block does
// - The port register holds one read/write reset bit per port, port H at bit 7 down to A at bit 0.
// - Writes to the port register only change bits enabled in capability mask four.
// - Reserved bits (31:8 of the port register; 31:13, 11:6 and 3 of the serial one) read zero.
// - The port register sits at offset 0x048 and resets to zero, no peripheral held in reset.
// - Bit 12 of the serial register is the read/write reset for two-wire unit 0, reset zero.
// - Bits 5 and 4 of the serial register reset sync serial units 1 and 0, reset zero.
// - Bits 2, 1 and 0 of the serial register reset async serial units 2, 1 and 0, reset zero.
// - The serial register sits at offset 0x044 and writes to it are gated by capability mask two.
`include "soft_reset_defs.svh"

module peripheral_soft_reset_regs (
   input  wire logic                       pclk,                  // System clock
   input  wire logic                       presetn,               // Async reset, active low
   input  wire logic                       psel,                  // APB select
   input  wire logic                       penable,               // APB access phase
   input  wire logic                       pwrite,                // APB write
   input  wire logic [`SRR_ADDR_W-1:0]     paddr,                 // APB byte address
   input  wire soft_reset_pkg::word_t      pwdata,                // APB write data
   output soft_reset_pkg::word_t           prdata,                // APB read data
   output logic                            pready,                // APB ready
   output logic                            pslverr,               // APB error, unmapped
   input  wire soft_reset_pkg::word_t      capability_mask_two,   // Serial write mask
   input  wire soft_reset_pkg::word_t      capability_mask_four,  // Port write mask
   output logic [7:0]                      port_reset,            // Port H..A held in reset
   output logic                            two_wire_unit0_reset,  // Two-wire unit 0 reset
   output logic [1:0]                      sync_serial_reset,     // Sync serial 1..0 reset
   output logic [2:0]                      async_serial_reset     // Async serial 2..0 reset
);
   import soft_reset_pkg::*;

   reset_bank_if serial_if ();
   reset_bank_if gpio_if ();

   reg_sel_t sel;
   logic     access;
   logic     wr_fire;
   word_t    prdata_r;
   word_t    prdata_nxt;
   logic     err_r;
   logic     err_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   always_comb begin
      unique case (paddr)
         `SRR_SERIAL_OFFSET: sel = SEL_SERIAL;
         `SRR_GPIO_OFFSET:   sel = SEL_GPIO;
         default:            sel = SEL_NONE;
      endcase
   end

   assign access  = psel && penable;
   assign wr_fire = access && pwrite && (sel != SEL_NONE);

   ////////////////////////////////////////////////////////////////////////
   // Write ports of the two banks
   assign serial_if.wr_en   = wr_fire && (sel == SEL_SERIAL);
   assign serial_if.wr_data = pwdata;
   assign serial_if.wr_mask = capability_mask_two;
   assign gpio_if.wr_en     = wr_fire && (sel == SEL_GPIO);
   assign gpio_if.wr_data   = pwdata;
   assign gpio_if.wr_mask   = capability_mask_four;

   reset_bank_reg #(
      .RESET_VALUE (`SRR_SERIAL_RESET),
      .IMPL_BITS   (`SRR_SERIAL_IMPL)
   ) u_serial (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (serial_if.bank)
   );

   reset_bank_reg #(
      .RESET_VALUE (`SRR_GPIO_RESET),
      .IMPL_BITS   (`SRR_GPIO_IMPL)
   ) u_gpio (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (gpio_if.bank)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read data and error captured in the setup phase, shown in the access phase
   always_comb begin
      prdata_nxt = prdata_r;
      err_nxt    = err_r;
      if (psel && !penable) begin
         err_nxt = (sel == SEL_NONE);
         unique case (sel)
            SEL_SERIAL: prdata_nxt = pwrite ? `SRR_ZERO_WORD : serial_if.value;
            SEL_GPIO:   prdata_nxt = pwrite ? `SRR_ZERO_WORD : gpio_if.value;
            default:    prdata_nxt = `SRR_ZERO_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `SRR_ZERO_WORD;
         err_r    <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         err_r    <= err_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = access && err_r;

   ////////////////////////////////////////////////////////////////////////
   // Reset levels to the peripherals, straight from the register flops
   assign port_reset              = gpio_if.value[`SRR_PORT_MSB:`SRR_PORT_LSB];
   assign two_wire_unit0_reset    = serial_if.value[`SRR_TWO_WIRE0_BIT];
   assign sync_serial_reset[1]    = serial_if.value[`SRR_SYNC1_BIT];
   assign sync_serial_reset[0]    = serial_if.value[`SRR_SYNC0_BIT];
   assign async_serial_reset[2]   = serial_if.value[`SRR_ASYNC2_BIT];
   assign async_serial_reset[1]   = serial_if.value[`SRR_ASYNC1_BIT];
   assign async_serial_reset[0]   = serial_if.value[`SRR_ASYNC0_BIT];

endmodule // peripheral_soft_reset_regs

/* File: shared/soft_reset_defs.svh */
`ifndef SOFT_RESET_DEFS_SVH
`define SOFT_RESET_DEFS_SVH

// Register byte offsets from the system control base
`define SRR_ADDR_W            12
`define SRR_SERIAL_OFFSET     12'h044
`define SRR_GPIO_OFFSET       12'h048

// Reset values
`define SRR_SERIAL_RESET      32'h0000_0000
`define SRR_GPIO_RESET        32'h0000_0000
`define SRR_ZERO_WORD         32'h0000_0000

// Writable bit positions; every other bit is reserved and reads zero
`define SRR_SERIAL_IMPL       32'h0000_1037
`define SRR_GPIO_IMPL         32'h0000_00ff

// Field positions in the serial register
`define SRR_TWO_WIRE0_BIT     12
`define SRR_SYNC1_BIT         5
`define SRR_SYNC0_BIT         4
`define SRR_ASYNC2_BIT        2
`define SRR_ASYNC1_BIT        1
`define SRR_ASYNC0_BIT        0

// Field positions in the port register
`define SRR_PORT_MSB          7
`define SRR_PORT_LSB          0

`endif

/* File: shared/soft_reset_pkg.sv */
package soft_reset_pkg;

   typedef logic [31:0] word_t;

   typedef enum logic [1:0] {
      SEL_NONE   = 2'b00,
      SEL_SERIAL = 2'b01,
      SEL_GPIO   = 2'b10
   } reg_sel_t;

endpackage

/* File: shared/reset_bank_if.sv */
interface reset_bank_if;
   import soft_reset_pkg::*;

   logic  wr_en;    // Write strobe, one cycle
   word_t wr_data;  // Data written by software
   word_t wr_mask;  // Capability mask for this write
   word_t value;    // Current register contents

   modport ctrl (output wr_en, output wr_data, output wr_mask, input value);
   modport bank (input wr_en, input wr_data, input wr_mask, output value);
endinterface

/* File: hdl/reset_bank_reg.sv */
`include "soft_reset_defs.svh"

module reset_bank_reg #(
   parameter soft_reset_pkg::word_t RESET_VALUE = `SRR_ZERO_WORD,
   parameter soft_reset_pkg::word_t IMPL_BITS   = `SRR_ZERO_WORD
) (
   input  wire logic   pclk,     // System clock
   input  wire logic   presetn,  // Asynchronous reset, active low
   reset_bank_if.bank  bus       // Write port and current value
);
   import soft_reset_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // One flop per implemented bit; reserved bits are constant zero
   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1) begin : g_bit
         if (IMPL_BITS[i]) begin : g_impl
            logic bit_r;
            logic bit_nxt;

            always_comb begin
               // Capability mask blocks writes to absent units
               if (bus.wr_en && bus.wr_mask[i]) begin
                  bit_nxt = bus.wr_data[i];
               end else begin
                  bit_nxt = bit_r;
               end
            end

            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  bit_r <= RESET_VALUE[i];
               end else begin
                  bit_r <= bit_nxt;
               end
            end

            assign bus.value[i] = bit_r;
         end else begin : g_rsvd
            assign bus.value[i] = 1'b0;
         end
      end
   endgenerate

endmodule // reset_bank_reg

/* File: bench/soft_reset_checker.sv */
module soft_reset_checker
   import soft_reset_pkg::*;
(
   input wire logic                  pclk,                 // Clock
   input wire logic                  presetn,              // Reset
   input wire logic                  psel,                 // Select
   input wire logic                  penable,              // Access
   input wire logic                  pwrite,               // Write
   input wire logic [11:0]           paddr,                // Address
   input wire soft_reset_pkg::word_t pwdata,               // Write data
   input wire soft_reset_pkg::word_t prdata,               // Read data
   input wire logic                  pready,               // Ready
   input wire logic                  pslverr,              // Error
   input wire soft_reset_pkg::word_t capability_mask_two,  // Serial mask
   input wire soft_reset_pkg::word_t capability_mask_four, // Port mask
   input wire logic [7:0]            port_reset,           // Ports
   input wire logic                  two_wire_unit0_reset, // Two-wire
   input wire logic [1:0]            sync_serial_reset,    // Sync
   input wire logic [2:0]            async_serial_reset    // Async
);
   wire logic [5:0] ser = {two_wire_unit0_reset, sync_serial_reset, async_serial_reset};
   wire logic [5:0] sd = {pwdata[12], pwdata[5:4], pwdata[2:0]};
   wire logic [5:0] sm = {capability_mask_two[12], capability_mask_two[5:4], capability_mask_two[2:0]};
   wire logic       acc = psel && penable;
   wire logic       wp = acc && pwrite && paddr == 12'h048;
   wire logic       ws = acc && pwrite && paddr == 12'h044;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   port_write_a: assert property (wp |=> port_reset ==
      (($past(pwdata[7:0]) & $past(capability_mask_four[7:0])) |
      ($past(port_reset) & ~$past(capability_mask_four[7:0])))) else $error("port write");
   port_hold_a: assert property (!wp |=> $stable(port_reset)) else $error("port hold");
   serial_write_a: assert property (ws |=>
      ser == (($past(sd) & $past(sm)) | ($past(ser) & ~$past(sm)))) else $error("serial write");
   serial_hold_a: assert property (!ws |=> $stable(ser)) else $error("serial hold");
   read_port_a: assert property (acc && !pwrite && paddr == 12'h048 |->
      prdata == {24'h0, port_reset}) else $error("port read");
   read_serial_a: assert property (acc && !pwrite && paddr == 12'h044 |->
      prdata == {19'h0, ser[5], 6'h0, ser[4:3], 1'b0, ser[2:0]}) else $error("serial read");
   unmapped_err_a: assert property (acc && paddr != 12'h044 && paddr != 12'h048 |->
      pslverr && prdata == 32'h0 && pready) else $error("unmapped");
   reset_zero_a: assert property ($rose(presetn) |->
      port_reset == 8'h00 && ser == 6'h00 && !pslverr) else $error("reset value");
endmodule // soft_reset_checker

bind peripheral_soft_reset_regs soft_reset_checker chk_i (.*);

/* File: bench/peripheral_soft_reset_regs_tb.sv */
module peripheral_soft_reset_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import soft_reset_pkg::*;
   typedef struct {logic [11:0] a; word_t d; word_t e;} row_t;
   logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, two_wire_unit0_reset, err;
   logic [11:0] paddr;
   word_t      pwdata, prdata, capability_mask_two, capability_mask_four, rd;
   logic [7:0] port_reset;
   logic [1:0] sync_serial_reset;
   logic [2:0] async_serial_reset;
   int         error_cnt = 0;
   int         checks = 0;
   word_t      masks [6] = '{32'hffffffff, 32'h0000000f, 32'hffffffff, 32'hffffffff, 32'h00000030, 32'hffffffff};
   row_t       rows [6] = '{'{12'h048, 32'hffffffff, 32'h000000ff}, '{12'h048, 32'h0, 32'h000000f0},
      '{12'h048, 32'h0000005a, 32'h0000005a}, '{12'h044, 32'hffffffff, 32'h00001037},
      '{12'h044, 32'h0, 32'h00001007}, '{12'h044, 32'h0, 32'h0}};
   peripheral_soft_reset_regs dut (.*);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic complete_run();
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(string n, word_t e, word_t s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic xfer(logic w, logic [11:0] a, word_t d);
      int t = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
      rd = prdata;
      err = pslverr;
      if (t >= 50) error_cnt++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic word_t outs(logic [11:0] a);
      if (a == 12'h048) return {24'h0, port_reset};
      return {19'h0, two_wire_unit0_reset, 6'h0, sync_serial_reset, 1'b0, async_serial_reset};
   endfunction
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      capability_mask_two = '1;
      capability_mask_four = '1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, 12'h044, 32'h0); chk("serial reset", 32'h0, rd);
      chk("mapped error", 32'h0, {31'h0, err});
      chk("ready", 32'h1, {31'h0, pready});
      xfer(1'b0, 12'h048, 32'h0); chk("port reset", 32'h0, rd);
      foreach (rows[i]) begin
         capability_mask_two <= masks[i];
         capability_mask_four <= masks[i];
         xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h0);
         chk("readback", rows[i].e, rd);
         chk("outputs", rows[i].e, outs(rows[i].a));
      end
      xfer(1'b1, 12'h048, 32'h000000a5);
      xfer(1'b1, 12'h04c, 32'hffffffff); chk("error flag", 32'h1, {31'h0, err});
      xfer(1'b0, 12'h048, 32'h0); chk("after unmapped", 32'h000000a5, rd);
      // Software side keeps the other bits by read-modify-write
      xfer(1'b1, 12'h048, rd | 32'h00000002);
      xfer(1'b0, 12'h048, 32'h0); chk("modify write", 32'h000000a7, rd);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset ports", 32'h0, outs(12'h048));
      complete_run();
   end
   initial begin
      #20us;
      error_cnt++;
      complete_run();
   end
endmodule // peripheral_soft_reset_regs_tb
